// [rtl/cte_core.sv]
// Tail execute unit: multiply, negate, test, list transfers, return, unlink, pause
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "cte_map.svh"

module cte_core (
	input  wire logic                clock,
	input  wire logic                arst_n,
	input  wire logic                instr_valid,
	output logic                     instr_ready,
	input  wire cte_pkg::cte_instr_t instr,
	output logic                     instr_done,
	output cte_pkg::cte_mem_t        mem_req,
	input  wire logic [15:0]         mem_rdata,
	input  wire logic [4:0]          bus_addr,
	input  wire logic [15:0]         bus_wdata,
	input  wire logic                bus_wr,
	input  wire logic                bus_rd,
	output logic [15:0]              bus_rdata,
	output logic                     cpu_clk_on,
	output logic                     io_clk_on,
	output logic                     fetch_only,
	input  wire logic                wake,
	input  wire logic                halt_release
);

	// ----------------
	// Helpers
	// ----------------
	function automatic logic [4:0] cte_popcount(input logic [15:0] m);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 16; i++) begin
			n = n + {4'h0, m[i]};
		end
		return n;
	endfunction

	function automatic logic [3:0] cte_lowest(input logic [15:0] m);
		logic [3:0] k;
		k = 4'hf;
		for (int i = 15; i >= 0; i--) begin
			if (m[i]) begin
				k = 4'(i);
			end
		end
		return k;
	endfunction

	function automatic logic [5:0] cte_list_cycles(input int base, input logic [15:0] m);
		return 6'(6'(base) + 6'(6'(`CTE_PER_REG) * {1'b0, cte_popcount(m)}));
	endfunction

	function automatic logic [5:0] cte_cycles(input cte_pkg::cte_instr_t ins);
		case (ins.op)
			cte_pkg::cte_signed_multiply_op,
			cte_pkg::cte_unsigned_multiply_op:   return 6'(`CTE_MUL_CYCLES);      // [RULE1] [RULE2]
			cte_pkg::cte_negate_op,
			cte_pkg::cte_negate_with_carry_op:   return 6'(`CTE_NEG_CYCLES);
			cte_pkg::cte_test_op,
			cte_pkg::cte_test_inverted_op:       return 6'(`CTE_TEST_CYCLES);
			cte_pkg::cte_multi_register_move_op: begin
				if (ins.to_memory) begin
					return cte_list_cycles(`CTE_STORE_BASE, ins.register_list_mask); // [RULE5]
				end
				return cte_list_cycles(`CTE_LOAD_BASE, ins.register_list_mask);
			end
			cte_pkg::cte_multi_register_push_op: return cte_list_cycles(`CTE_STORE_BASE, ins.register_list_mask);
			cte_pkg::cte_multi_register_pop_op:  return cte_list_cycles(`CTE_LOAD_BASE, ins.register_list_mask);
			cte_pkg::cte_interrupt_return_op:    return 6'(`CTE_INTERRUPT_RETURN_OP_CYCLES);     // [RULE6]
			cte_pkg::cte_frame_unlink_op:        return 6'(`CTE_FRAME_UNLINK_OP_CYCLES);     // [RULE9]
			cte_pkg::cte_stop_op,
			cte_pkg::cte_idle_op,
			cte_pkg::cte_halt_op:                return 6'(`CTE_PAUSE_CYCLES);
			default:                             return 6'(`CTE_NOP_CYCLES);
		endcase
	endfunction

	// Undefined flags keep their old value so software sees no spurious change
	function automatic logic cte_flag(input cte_pkg::cte_flag_act_t a, input logic old, input logic res);
		case (a)
			cte_pkg::cte_fl_result: return res;
			cte_pkg::cte_fl_set:    return 1'b1;
			cte_pkg::cte_fl_clear:  return 1'b0;
			default:                return old;
		endcase
	endfunction

	// ----------------
	// State
	// ----------------
	cte_pkg::cte_state_t state_reg, state_next;
	cte_pkg::cte_instr_t cur_reg, cur_next;
	cte_pkg::cte_mem_t   mem_reg, mem_next;
	cte_pkg::cte_pend_t  pend_a_reg, pend_a_next;
	cte_pkg::cte_pend_t  pend_b_reg, pend_b_next;
	logic [5:0]          cnt_reg, cnt_next;
	logic [5:0]          total_reg, total_next;
	logic [15:0]         list_reg, list_next;
	logic [1:0]          sub_reg, sub_next;
	logic [31:0]         prod_reg, prod_next;
	logic [15:0]         rf_reg [16];
	logic [15:0]         rf_next [16];
	logic [15:0]         sp_reg, sp_next;
	logic [15:0]         pc_reg, pc_next;
	logic [15:0]         sr_reg, sr_next;
	logic                done_reg, done_next;
	logic                io_off_reg, io_off_next;
	logic [15:0]         rdata_reg, rdata_next;

	logic [3:0]          even_idx, slot_idx;
	logic [15:0]         dval, aval, tval, res;
	logic [16:0]         w17;
	logic [8:0]          b9;
	logic                r_n, r_z, r_v, r_c;
	cte_pkg::cte_flag_act_t act_n, act_z, act_v, act_c;
	logic                last;

	assign instr_ready = (state_reg == cte_pkg::cte_st_ready);
	assign instr_done  = done_reg;
	assign mem_req     = mem_reg;
	assign bus_rdata   = rdata_reg;
	assign cpu_clk_on  = (state_reg != cte_pkg::cte_st_pause);                 // [RULE7] [RULE11]
	assign io_clk_on   = !((state_reg == cte_pkg::cte_st_pause) && io_off_reg); // [RULE7] [RULE11]
	assign fetch_only  = (state_reg == cte_pkg::cte_st_halt);                   // [RULE12]

	// ----------------
	// Next-state logic
	// ----------------
	always_comb begin
		state_next  = state_reg;
		cur_next    = cur_reg;
		mem_next    = '0;
		pend_a_next = '0;
		pend_b_next = pend_a_reg;
		cnt_next    = cnt_reg;
		total_next  = total_reg;
		list_next   = list_reg;
		sub_next    = sub_reg;
		prod_next   = prod_reg;
		rf_next     = rf_reg;
		sp_next     = sp_reg;
		pc_next     = pc_reg;
		sr_next     = sr_reg;
		done_next   = 1'b0;
		io_off_next = io_off_reg;
		rdata_next  = 16'h0000;
		even_idx    = {cur_reg.ry[3:1], 1'b0}; // [RULE13]
		slot_idx    = cte_lowest(list_reg);
		dval        = rf_reg[cur_reg.ry];
		aval        = rf_reg[cur_reg.ry];
		last        = (cnt_reg == 6'(total_reg - 6'h01));
		act_n       = cte_pkg::cte_fl_keep;
		act_z       = cte_pkg::cte_fl_keep;
		act_v       = cte_pkg::cte_fl_keep;
		act_c       = cte_pkg::cte_fl_keep;

		// Negate and test results, byte forms touch the low byte only
		w17 = 17'h00000 - {1'b0, dval} - {16'h0000, (cur_reg.op == cte_pkg::cte_negate_with_carry_op) &&
			sr_reg[`CTE_FLAG_C]}; // [RULE3]
		b9  = 9'h000 - {1'b0, dval[7:0]} - {8'h00, (cur_reg.op == cte_pkg::cte_negate_with_carry_op) &&
			sr_reg[`CTE_FLAG_C]}; // [RULE3]
		tval = cur_reg.imm & ((cur_reg.op == cte_pkg::cte_test_inverted_op) ? ~dval : dval); // [RULE8]
		if (cur_reg.op == cte_pkg::cte_test_op || cur_reg.op == cte_pkg::cte_test_inverted_op) begin
			res = tval;
			r_v = 1'b0;
			r_c = 1'b0;
			act_n = cte_pkg::cte_fl_result; // [RULE8]
			act_z = cte_pkg::cte_fl_result;
			act_v = cte_pkg::cte_fl_clear;
			act_c = cte_pkg::cte_fl_clear;
		end else if (cur_reg.byte_size) begin
			res = {dval[15:8], b9[7:0]};
			r_v = dval[7] & b9[7];
			r_c = b9[8];
			act_n = cte_pkg::cte_fl_result; // [RULE10]
			act_z = cte_pkg::cte_fl_result;
			act_v = cte_pkg::cte_fl_result;
			act_c = cte_pkg::cte_fl_result;
		end else begin
			res = w17[15:0];
			r_v = dval[15] & w17[15];
			r_c = w17[16];
			act_n = cte_pkg::cte_fl_result;
			act_z = cte_pkg::cte_fl_result;
			act_v = cte_pkg::cte_fl_result;
			act_c = cte_pkg::cte_fl_result;
		end
		r_n = cur_reg.byte_size ? res[7] : res[15];
		r_z = cur_reg.byte_size ? (res[7:0] == 8'h00) : (res == 16'h0000);

		// Software access has the lowest priority; execution overrides it below
		if (bus_wr) begin
			if (bus_addr <= `CTE_OFS_REG_LAST) begin
				rf_next[bus_addr[3:0]] = bus_wdata;
			end else if (bus_addr == `CTE_OFS_SP) begin
				sp_next = bus_wdata;
			end else if (bus_addr == `CTE_OFS_PC) begin
				pc_next = bus_wdata;
			end else if (bus_addr == `CTE_OFS_STATUS) begin
				sr_next = bus_wdata;
			end
		end
		if (bus_rd) begin
			if (bus_addr <= `CTE_OFS_REG_LAST) begin
				rdata_next = rf_reg[bus_addr[3:0]];
			end else if (bus_addr == `CTE_OFS_SP) begin
				rdata_next = sp_reg;
			end else if (bus_addr == `CTE_OFS_PC) begin
				rdata_next = pc_reg;
			end else if (bus_addr == `CTE_OFS_STATUS) begin
				rdata_next = sr_reg;
			end else if (bus_addr == `CTE_OFS_STATE) begin
				rdata_next = {12'h000, io_off_reg, 1'b0, state_reg};
			end
		end

		// Memory read data lands two cycles after the slot that asked for it
		if (pend_b_reg.valid) begin
			if (pend_b_reg.dst[4] == 1'b0) begin
				rf_next[pend_b_reg.dst[3:0]] = mem_rdata;
			end else if (pend_b_reg.dst == 5'h10) begin
				sr_next = mem_rdata; // [RULE6]
			end else begin
				pc_next = mem_rdata; // [RULE6]
			end
		end

		case (state_reg)
			cte_pkg::cte_st_ready: begin
				if (instr_valid) begin
					cur_next   = instr;
					cnt_next   = 6'h00;
					sub_next   = 2'h0;
					total_next = cte_cycles(instr);
					list_next  = instr.register_list_mask;                      // [RULE4]
					state_next = cte_pkg::cte_st_exec;
					if (instr.op == cte_pkg::cte_signed_multiply_op) begin
						prod_next = 32'($signed(rf_reg[instr.rx]) *
							$signed(rf_reg[{instr.ry[3:1], 1'b0}]));            // [RULE1]
					end else begin
						prod_next = rf_reg[instr.rx] * rf_reg[{instr.ry[3:1], 1'b0}]; // [RULE2]
					end
				end
			end
			cte_pkg::cte_st_exec: begin
				cnt_next = 6'(cnt_reg + 6'h01);
				// List transfers: one register every three cycles, lowest index first
				if (cnt_reg >= 6'(`CTE_LIST_START)) begin
					sub_next = (sub_reg == 2'h2) ? 2'h0 : 2'(sub_reg + 2'h1);
				end
				if (cnt_reg >= 6'(`CTE_LIST_START) && sub_reg == 2'h0 && list_reg != 16'h0000) begin
					list_next[slot_idx] = 1'b0;
					case (cur_reg.op)
						cte_pkg::cte_multi_register_move_op: begin
							mem_next.addr = cur_reg.predec ? 16'(aval - 16'h0002) : aval;
							rf_next[cur_reg.ry] = cur_reg.predec ? 16'(aval - 16'h0002) :
								16'(aval + 16'h0002);
							if (cur_reg.to_memory) begin
								mem_next.wr    = 1'b1;                           // [RULE5]
								mem_next.wdata = rf_reg[slot_idx];
							end else begin
								mem_next.rd = 1'b1;
								pend_a_next = '{valid: 1'b1, dst: {1'b0, slot_idx}};
							end
						end
						cte_pkg::cte_multi_register_push_op: begin
							sp_next        = 16'(sp_reg - 16'h0002);
							mem_next.wr    = 1'b1;
							mem_next.addr  = 16'(sp_reg - 16'h0002);
							mem_next.wdata = rf_reg[slot_idx];
						end
						cte_pkg::cte_multi_register_pop_op: begin
							sp_next       = 16'(sp_reg + 16'h0002);
							mem_next.rd   = 1'b1;
							mem_next.addr = sp_reg;
							pend_a_next   = '{valid: 1'b1, dst: {1'b0, slot_idx}};
						end
						default: begin
						end
					endcase
				end
				if (cur_reg.op == cte_pkg::cte_interrupt_return_op &&
					(cnt_reg == 6'(`CTE_INTERRUPT_RETURN_OP_SR_AT) || cnt_reg == 6'(`CTE_INTERRUPT_RETURN_OP_PC_AT))) begin
					sp_next       = 16'(sp_reg + 16'h0002);                     // [RULE6]
					mem_next.rd   = 1'b1;
					mem_next.addr = sp_reg;
					pend_a_next   = '{valid: 1'b1, dst: (cnt_reg == 6'(`CTE_INTERRUPT_RETURN_OP_SR_AT)) ? 5'h10 : 5'h11};
				end
				if (cur_reg.op == cte_pkg::cte_frame_unlink_op) begin
					if (cnt_reg == 6'(`CTE_FRAME_UNLINK_OP_SP_AT)) begin
						sp_next = rf_reg[cur_reg.rx];                           // [RULE9]
					end else if (cnt_reg == 6'(`CTE_FRAME_UNLINK_OP_POP_AT)) begin
						sp_next       = 16'(sp_reg + 16'h0002);                 // [RULE9]
						mem_next.rd   = 1'b1;
						mem_next.addr = sp_reg;
						pend_a_next   = '{valid: 1'b1, dst: {1'b0, cur_reg.rx}};
					end
				end
				if (last) begin
					done_next  = 1'b1;
					state_next = cte_pkg::cte_st_ready;
					case (cur_reg.op)
						cte_pkg::cte_signed_multiply_op,
						cte_pkg::cte_unsigned_multiply_op: begin
							rf_next[even_idx]         = prod_reg[31:16];        // [RULE1] [RULE2]
							rf_next[even_idx | 4'h1]  = prod_reg[15:0];         // [RULE13]
						end
						cte_pkg::cte_negate_op,
						cte_pkg::cte_negate_with_carry_op: begin
							rf_next[cur_reg.ry] = res;                          // [RULE3]
						end
						cte_pkg::cte_stop_op: begin
							state_next  = cte_pkg::cte_st_pause;                // [RULE7]
							io_off_next = 1'b1;
						end
						cte_pkg::cte_idle_op: begin
							state_next  = cte_pkg::cte_st_pause;                // [RULE11]
							io_off_next = 1'b0;
						end
						cte_pkg::cte_halt_op: begin
							state_next = cte_pkg::cte_st_halt;                  // [RULE12]
						end
						default: begin
						end
					endcase
					if (cur_reg.op inside {cte_pkg::cte_negate_op, cte_pkg::cte_negate_with_carry_op, // [RULE10]
						cte_pkg::cte_test_op, cte_pkg::cte_test_inverted_op}) begin
						sr_next[`CTE_FLAG_N] = cte_flag(act_n, sr_reg[`CTE_FLAG_N], r_n);
						sr_next[`CTE_FLAG_Z] = cte_flag(act_z, sr_reg[`CTE_FLAG_Z], r_z);
						sr_next[`CTE_FLAG_V] = cte_flag(act_v, sr_reg[`CTE_FLAG_V], r_v);
						sr_next[`CTE_FLAG_C] = cte_flag(act_c, sr_reg[`CTE_FLAG_C], r_c);
					end
					if (cur_reg.op != cte_pkg::cte_interrupt_return_op) begin
						// Two-word forms carry a mask or an immediate in the extension word
						if (cur_reg.op == cte_pkg::cte_test_op || cur_reg.op == cte_pkg::cte_test_inverted_op ||
							cur_reg.op == cte_pkg::cte_multi_register_move_op ||
							cur_reg.op == cte_pkg::cte_multi_register_push_op ||
							cur_reg.op == cte_pkg::cte_multi_register_pop_op) begin
							pc_next = 16'(pc_reg + 16'h0004);                   // [RULE5]
						end else begin
							pc_next = 16'(pc_reg + 16'h0002);                   // [RULE11] [RULE12]
						end
					end
				end
			end
			cte_pkg::cte_st_pause: begin
				if (wake) begin
					state_next  = cte_pkg::cte_st_ready;                        // [RULE7]
					io_off_next = 1'b0;
				end
			end
			default: begin
				if (halt_release) begin
					state_next = cte_pkg::cte_st_ready;                         // [RULE12]
				end
			end
		endcase
	end

	// ----------------
	// Registers
	// ----------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg  <= cte_pkg::cte_st_ready;
			cur_reg    <= '0;
			mem_reg    <= '0;
			pend_a_reg <= '0;
			pend_b_reg <= '0;
			cnt_reg    <= 6'h00;
			total_reg  <= 6'h01;
			list_reg   <= 16'h0000;
			sub_reg    <= 2'h0;
			prod_reg   <= 32'h00000000;
			for (int i = 0; i < 16; i++) begin
				rf_reg[i] <= 16'h0000;
			end
			sp_reg     <= `CTE_SP_RESET;
			pc_reg     <= `CTE_PC_RESET;
			sr_reg     <= `CTE_STATUS_RESET;
			done_reg   <= 1'b0;
			io_off_reg <= 1'b0;
			rdata_reg  <= 16'h0000;
		end else begin
			state_reg  <= state_next;
			cur_reg    <= cur_next;
			mem_reg    <= mem_next;
			pend_a_reg <= pend_a_next;
			pend_b_reg <= pend_b_next;
			cnt_reg    <= cnt_next;
			total_reg  <= total_next;
			list_reg   <= list_next;
			sub_reg    <= sub_next;
			prod_reg   <= prod_next;
			rf_reg     <= rf_next;
			sp_reg     <= sp_next;
			pc_reg     <= pc_next;
			sr_reg     <= sr_next;
			done_reg   <= done_next;
			io_off_reg <= io_off_next;
			rdata_reg  <= rdata_next;
		end
	end

endmodule // cte_core

// [rtl/cte_map.svh]
// Constants for the tail execute unit: map offsets, flag positions, cycle counts
//
// Contract
// RULE1: Signed multiply into even/odd pair, 21 cycles
// RULE2: Unsigned 32-bit product high-even low-odd, 21 cycles
// RULE3: Negate writes 0-dst, carry form subtracts carry
// RULE4: Register lists name at least two registers
// RULE5: List store takes 7+3r cycles, two words
// RULE6: Interrupt return pops status, then program counter
// RULE7: Stop halts CPU and I/O clocks until wake
// RULE8: Test ANDs source with (inverted) dest, N Z, clear V C
// RULE9: Unlink copies register to SP, pops it, 6 cycles
// RULE10: Each flag follows its column action
// RULE11: Idle advances PC, CPU clocks off, I/O runs
// RULE12: Halt advances PC by two, fetches until release
// RULE13: Multiply pair base register is even
`ifndef CTE_MAP_SVH
`define CTE_MAP_SVH

// ----------------
// Register map (word index)
// ----------------
`define CTE_OFS_REG_LAST 5'h0f
`define CTE_OFS_SP       5'h10
`define CTE_OFS_PC       5'h11
`define CTE_OFS_STATUS   5'h12
`define CTE_OFS_STATE    5'h13

// ----------------
// Status word layout and reset values
// ----------------
`define CTE_FLAG_C       0
`define CTE_FLAG_Z       1
`define CTE_FLAG_V       2
`define CTE_FLAG_N       3
`define CTE_STATUS_RESET 16'h0000
`define CTE_SP_RESET     16'h0000
`define CTE_PC_RESET     16'h0000

// ----------------
// Cycle counts
// ----------------
`define CTE_MUL_CYCLES   21
`define CTE_NEG_CYCLES   3
`define CTE_NOP_CYCLES   3
`define CTE_TEST_CYCLES  6
`define CTE_STORE_BASE   7
`define CTE_LOAD_BASE    9
`define CTE_PER_REG      3
`define CTE_INTERRUPT_RETURN_OP_CYCLES  12
`define CTE_FRAME_UNLINK_OP_CYCLES  6
`define CTE_PAUSE_CYCLES 1
`define CTE_LIST_START   3
`define CTE_INTERRUPT_RETURN_OP_SR_AT   2
`define CTE_INTERRUPT_RETURN_OP_PC_AT   5
`define CTE_FRAME_UNLINK_OP_SP_AT   1
`define CTE_FRAME_UNLINK_OP_POP_AT  2

`endif

// [rtl/cte_pkg.sv]
// Types shared by the tail execute unit
package cte_pkg;

	typedef enum logic [3:0] {
		cte_nop_op                 = 4'h0,
		cte_signed_multiply_op     = 4'h1,
		cte_unsigned_multiply_op   = 4'h2,
		cte_negate_op              = 4'h3,
		cte_negate_with_carry_op   = 4'h4,
		cte_test_op                = 4'h5,
		cte_test_inverted_op       = 4'h6,
		cte_multi_register_move_op = 4'h7,
		cte_multi_register_push_op = 4'h8,
		cte_multi_register_pop_op  = 4'h9,
		cte_interrupt_return_op    = 4'ha,
		cte_frame_unlink_op        = 4'hb,
		cte_stop_op                = 4'hc,
		cte_idle_op                = 4'hd,
		cte_halt_op                = 4'he
	} cte_op_t;

	typedef enum logic [2:0] {
		cte_fl_result = 3'h0,
		cte_fl_set    = 3'h1,
		cte_fl_clear  = 3'h2,
		cte_fl_keep   = 3'h3,
		cte_fl_undef  = 3'h4
	} cte_flag_act_t;

	typedef enum logic [1:0] {
		cte_st_ready = 2'b00,
		cte_st_exec  = 2'b01,
		cte_st_pause = 2'b10,
		cte_st_halt  = 2'b11
	} cte_state_t;

	typedef struct packed {
		cte_op_t     op;
		logic        byte_size;
		logic        to_memory;
		logic        predec;
		logic [3:0]  rx;
		logic [3:0]  ry;
		logic [15:0] register_list_mask;
		logic [15:0] imm;
	} cte_instr_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} cte_mem_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] dst;
	} cte_pend_t;

endpackage

// [verif/cte_core_props.sv]
// Port-level checker for the tail execute unit
`timescale 1ns/1ps
module cte_core_props (
	input logic                clock,
	input logic                arst_n,
	input logic                instr_valid,
	input logic                instr_ready,
	input cte_pkg::cte_instr_t instr,
	input logic                instr_done,
	input logic                cpu_clk_on,
	input logic                io_clk_on,
	input logic                fetch_only,
	input logic                wake,
	input logic                halt_release
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic [5:0]       cnt_reg, cnt_next, len_reg, len_next;
	cte_pkg::cte_op_t op_reg, op_next;
	wire              take = instr_valid && instr_ready;
	function automatic logic [5:0] t_len(cte_pkg::cte_instr_t i);
		logic [5:0] r;
		r = 6'($countones(i.register_list_mask));
		case (i.op)
			cte_pkg::cte_signed_multiply_op, cte_pkg::cte_unsigned_multiply_op: return 6'h15;
			cte_pkg::cte_test_op, cte_pkg::cte_test_inverted_op, cte_pkg::cte_frame_unlink_op: return 6'h06;
			cte_pkg::cte_multi_register_push_op: return 6'h07 + 6'h03 * r;
			cte_pkg::cte_multi_register_pop_op: return 6'h09 + 6'h03 * r;
			cte_pkg::cte_multi_register_move_op: return (i.to_memory ? 6'h07 : 6'h09) + 6'h03 * r;
			cte_pkg::cte_interrupt_return_op: return 6'h0c;
			cte_pkg::cte_stop_op, cte_pkg::cte_idle_op, cte_pkg::cte_halt_op: return 6'h01;
			default: return 6'h03;
		endcase
	endfunction
	always_comb begin
		cnt_next = (cnt_reg != 6'h00 && !instr_done) ? cnt_reg + 6'h01 : 6'h00;
		len_next = take ? t_len(instr) : len_reg;
		op_next = take ? instr.op : op_reg;
		if (take)
			cnt_next = 6'h01;
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 6'h00;
			len_reg <= 6'h00;
			op_reg <= cte_pkg::cte_nop_op;
		end else begin
			cnt_reg <= cnt_next;
			len_reg <= len_next;
			op_reg <= op_next;
		end
	end
	done_latency_a: assert property (instr_done |-> cnt_reg == len_reg + 6'h01)
		else $error("done late");
	mul_time_a: assert property (take && instr.op inside {cte_pkg::cte_signed_multiply_op,
		cte_pkg::cte_unsigned_multiply_op} |-> ##1 (!instr_done)[*8] ##14 instr_done)
		else $error("mul time");
	interrupt_return_op_time_a: assert property (take && instr.op == cte_pkg::cte_interrupt_return_op |-> ##13 instr_done)
		else $error("return time");
	frame_unlink_op_time_a: assert property (take && instr.op == cte_pkg::cte_frame_unlink_op
		|-> ##1 (!instr_done)[*6] ##1 instr_done) else $error("unlink time");
	test_busy_a: assert property (take && instr.op inside {cte_pkg::cte_test_op, cte_pkg::cte_test_inverted_op}
		|-> ##1 (!instr_ready && !instr_done)[*5] ##2 instr_done) else $error("test time");
	stop_clocks_a: assert property (!cpu_clk_on && op_reg == cte_pkg::cte_stop_op |-> !io_clk_on)
		else $error("stop io on");
	idle_io_a: assert property (!cpu_clk_on && op_reg == cte_pkg::cte_idle_op |-> io_clk_on)
		else $error("idle io off");
	pause_hold_a: assert property (!cpu_clk_on && !wake |=> !cpu_clk_on && !instr_ready)
		else $error("early wake");
	wake_exit_a: assert property (!cpu_clk_on && wake |-> ##[1:2] cpu_clk_on)
		else $error("no wake");
	halt_fetch_a: assert property (fetch_only |-> !instr_ready && cpu_clk_on)
		else $error("halt took op");
	halt_exit_a: assert property (fetch_only && halt_release |-> ##[1:2] !fetch_only)
		else $error("no release");
endmodule // cte_core_props

bind cte_core cte_core_props i_props (.clock, .arst_n, .instr_valid, .instr_ready, .instr, .instr_done,
	.cpu_clk_on, .io_clk_on, .fetch_only, .wake, .halt_release);

// [verif/tb_top.sv]
// Self-checking bench for the tail execute unit
`timescale 1ns/1ps
module tb_top;
	logic                clock, arst_n, instr_valid, instr_ready, instr_done, bus_wr, bus_rd, cpu_clk_on, io_clk_on;
	logic                fetch_only, wake, halt_release;
	cte_pkg::cte_instr_t instr;
	cte_pkg::cte_mem_t   mem_req;
	logic [15:0]         mem_rdata = 16'h0000;
	logic [4:0]          bus_addr;
	logic [15:0]         bus_wdata, bus_rdata;
	logic [15:0]         mem [0:255];
	logic [15:0]         vals [0:15];
	int                  err_total = 0, num_checks = 0, cyc = 0, wr_cnt = 0, seed;

	cte_core i_dut (.clock, .arst_n, .instr_valid, .instr_ready, .instr, .instr_done, .mem_req, .mem_rdata,
		.bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .cpu_clk_on, .io_clk_on, .fetch_only, .wake,
		.halt_release);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ----------------
	// Memory side
	// ----------------
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (mem_req.wr === 1'b1) begin
			mem[mem_req.addr[8:1]] <= mem_req.wdata;
			wr_cnt <= wr_cnt + 1;
		end
		mem_rdata <= (mem_req.rd === 1'b1) ? mem[mem_req.addr[8:1]] : ~mem_rdata;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clock);
		bus_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [4:0] a, input logic [15:0] e);
		@(posedge clock);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clock);
		bus_rd <= 1'b0;
		@(negedge clock);
		chk(bus_rdata, e);
	endtask

	function automatic cte_pkg::cte_instr_t mk(cte_pkg::cte_op_t op, logic [3:0] rx, logic [3:0] ry,
		logic [15:0] m = 16'h0000, logic [15:0] imm = 16'h0000, logic tm = 1'b0, logic pd = 1'b0);
		cte_pkg::cte_instr_t i;
		i = '0;
		i.op = op;
		i.rx = rx;
		i.ry = ry;
		i.register_list_mask = m;
		i.imm = imm;
		i.to_memory = tm;
		i.predec = pd;
		return i;
	endfunction

	// Offer one instruction, hold it until taken, then wait for done
	task automatic run(input cte_pkg::cte_instr_t i);
		int n;
		@(posedge clock);
		instr <= i;
		instr_valid <= 1'b1;
		n = 0;
		@(negedge clock);
		while (instr_ready !== 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		@(posedge clock);
		instr_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (instr_done !== 1'b1 && n < 100);
		if (n >= 100)
			err_total++;
	endtask

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		logic [15:0] a, b, v;
		logic [31:0] p;
		logic [3:0]  rx, ry, f;
		logic        cn;
		logic [4:0]  bs;
		cte_pkg::cte_op_t op;
		int r, n;
		int idx [16];
		seed = 32'h8a14;
		{arst_n, instr_valid, bus_wr, bus_rd, wake, halt_release} = '0;
		instr = '0;
		bus_addr = 5'h00;
		bus_wdata = 16'h0000;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		rchk(5'h12, 16'h0000);
		wr(5'h1f, 16'h5a5a);
		rchk(5'h1f, 16'h0000);
		for (int k = 0; k < 6; k++) begin
			a = (k == 0) ? 16'h8000 : 16'($random(seed));
			b = (k == 0) ? 16'hffff : 16'($random(seed));
			ry = 4'($random(seed)) & 4'he;
			rx = ry + 4'h2;
			f = 4'($random(seed));
			wr({1'b0, rx}, a);
			wr({1'b0, ry}, b);
			wr(5'h12, {12'h000, f});
			op = k[0] ? cte_pkg::cte_unsigned_multiply_op : cte_pkg::cte_signed_multiply_op;
			run(mk(op, rx, ry));
			if (k[0])
				p = a * b;
			else
				p = $signed(a) * $signed(b);
			rchk({1'b0, ry}, p[31:16]);
			rchk({1'b0, ry | 4'h1}, p[15:0]);
			rchk(5'h12, {12'h000, f});
		end
		for (int k = 0; k < 8; k++) begin
			a = (k < 2) ? 16'h0000 : (k < 4) ? 16'h8000 : 16'($random(seed));
			cn = k[1] ^ k[2];
			ry = 4'($random(seed));
			wr({1'b0, ry}, a);
			wr(5'h12, {15'h0000, cn});
			op = k[0] ? cte_pkg::cte_negate_with_carry_op : cte_pkg::cte_negate_op;
			run(mk(op, 4'h0, ry));
			v = 16'h0000 - a - {15'h0000, cn & k[0]};
			rchk({1'b0, ry}, v);
			rchk(5'h12, {12'h000, v[15], a[15] & v[15], v == 16'h0000, (a != 16'h0000) | (cn & k[0])});
		end
		for (int k = 0; k < 6; k++) begin
			a = (k < 2) ? 16'h0000 : 16'($random(seed));
			b = 16'($random(seed));
			ry = 4'($random(seed));
			wr({1'b0, ry}, b);
			wr(5'h12, 16'h000f);
			op = k[0] ? cte_pkg::cte_test_inverted_op : cte_pkg::cte_test_op;
			run(mk(op, 4'h0, ry, 16'h0000, a));
			v = a & (k[0] ? ~b : b);
			rchk(5'h12, {12'h000, v[15], 1'b0, v == 16'h0000, 1'b0});
			rchk({1'b0, ry}, b);
		end
		for (int k = 0; k < 4; k++) begin
			a = (k == 0) ? 16'h0003 : (k == 1) ? 16'h7fff : (16'($random(seed)) & 16'h7fff) | 16'h0005;
			r = $countones(a);
			bs = k[0] ? 5'h10 : 5'h0f;
			n = 0;
			for (int q = 0; q < 15; q++) begin
				vals[q] = 16'($random(seed));
				if (a[q]) begin
					wr(5'(q), vals[q]);
					idx[n] = q;
					n++;
				end
			end
			wr(bs, 16'h0080);
			b = 16'(wr_cnt);
			run(k[0] ? mk(cte_pkg::cte_multi_register_push_op, 4'h0, 4'h0, a)
				: mk(cte_pkg::cte_multi_register_move_op, 4'h0, 4'hf, a, 16'h0000, 1'b1, 1'b1));
			chk(16'(wr_cnt) - b, 16'(r));
			rchk(bs, 16'h0080 - 16'(2 * r));
			for (int q = 0; q < 15; q++)
				if (a[q])
					wr(5'(q), ~vals[q]);
			run(k[0] ? mk(cte_pkg::cte_multi_register_pop_op, 4'h0, 4'h0, a)
				: mk(cte_pkg::cte_multi_register_move_op, 4'h0, 4'hf, a));
			// Lowest index goes first both ways, so the list comes back reversed
			for (int q = 0; q < r; q++)
				rchk(5'(idx[q]), vals[idx[r - 1 - q]]);
			rchk(bs, 16'h0080);
		end
		f = 4'($random(seed));
		a = 16'($random(seed)) & 16'hfff0;
		b = 16'($random(seed));
		mem[8'h20] = {12'h000, f};
		mem[8'h21] = a;
		mem[8'h30] = b;
		wr(5'h10, 16'h0040);
		run(mk(cte_pkg::cte_interrupt_return_op, 4'h0, 4'h0));
		rchk(5'h12, {12'h000, f});
		rchk(5'h11, a);
		rchk(5'h10, 16'h0044);
		wr(5'h03, 16'h0060);
		wr(5'h10, 16'h0010);
		run(mk(cte_pkg::cte_frame_unlink_op, 4'h3, 4'h0));
		rchk(5'h10, 16'h0062);
		rchk(5'h03, b);
		for (int k = 0; k < 3; k++) begin
			op = (k == 0) ? cte_pkg::cte_stop_op : (k == 1) ? cte_pkg::cte_idle_op : cte_pkg::cte_halt_op;
			wr(5'h11, 16'h0100);
			run(mk(op, 4'h0, 4'h0));
			@(posedge clock);
			instr <= mk(cte_pkg::cte_signed_multiply_op, 4'h2, 4'h0);
			instr_valid <= 1'b1;
			repeat (4) @(negedge clock);
			chk({12'h000, instr_ready, cpu_clk_on, io_clk_on, fetch_only},
				{12'h000, 1'b0, k == 2, k != 0, k == 2});
			@(posedge clock);
			instr_valid <= 1'b0;
			wake <= (k != 2);
			halt_release <= (k == 2);
			@(posedge clock);
			wake <= 1'b0;
			halt_release <= 1'b0;
			repeat (3) @(negedge clock);
			chk({12'h000, instr_ready, cpu_clk_on, io_clk_on, fetch_only}, 16'h000e);
			rchk(5'h11, 16'h0102);
		end
		close_out();
	end
endmodule // tb_top
